// ---- design/rgmii_port_pkg.sv ----
package rgmii_port_pkg;

    // system clock and link clock rates, in hertz
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int RATE_1000_HZ = 125_000_000;
    localparam int RATE_100_HZ = 25_000_000;
    localparam int RATE_10_HZ = 2_500_000;
    localparam int REF_CLK_HZ = 125_000_000;

    // link clock periods in system clock cycles (must divide evenly)
    localparam int DIV_W = 6;
    localparam logic [DIV_W-1:0] PERIOD_1000 =
        DIV_W'(SYS_CLK_HZ / RATE_1000_HZ);
    localparam logic [DIV_W-1:0] PERIOD_100 =
        DIV_W'(SYS_CLK_HZ / RATE_100_HZ);
    localparam logic [DIV_W-1:0] PERIOD_10 =
        DIV_W'(SYS_CLK_HZ / RATE_10_HZ);

    // line speed encoding, shared by status nibble and speed input
    typedef enum logic [1:0] {
        SPEED_10 = 2'b00,
        SPEED_100 = 2'b01,
        SPEED_1000 = 2'b10
    } speed_t;

    // port sequencing after reset
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_RUN = 2'b01
    } port_state_t;

    // in-band status nibble layout
    localparam int STAT_LINK_BIT = 0;
    localparam int STAT_SPEED_LSB = 1;
    localparam int STAT_DUPLEX_BIT = 3;

    // strap layout: mode bits on rx data and rx clock, ref enable on ctl
    localparam int STRAP_MODE_W = 5;
    localparam int STRAP_VEC_W = 6;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // transmit entry layout crossing to the system domain
    localparam int TX_ENTRY_W = 10;
    localparam int ENTRY_ERR_BIT = 8;
    localparam int ENTRY_VALID_BIT = 9;
    localparam int FIFO_ADDR_W = 3;

    function automatic logic [FIFO_ADDR_W:0] bin2gray(
        input logic [FIFO_ADDR_W:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [DIV_W-1:0] periodOf(input speed_t s);
        case (s)
            SPEED_1000: periodOf = PERIOD_1000;
            SPEED_100: periodOf = PERIOD_100;
            default: periodOf = PERIOD_10;
        endcase
    endfunction : periodOf

endpackage : rgmii_port_pkg

// ---- design/rgmii_tx_capture.sv ----
`timescale 1ns/1ps
// transmit side on the mac's own clock: double-edge capture, byte
// assembly, and a gray-pointer queue toward the system domain
module rgmii_tx_capture
    import rgmii_port_pkg::*;
(
    input wire logic txClk,
    input wire logic resetn,
    input wire logic [3:0] txData,
    input wire logic txCtl,
    input wire rgmii_port_pkg::speed_t speed,
    input wire logic [FIFO_ADDR_W:0] rptrGray,
    input wire logic [FIFO_ADDR_W-1:0] rdAddr,
    output logic [TX_ENTRY_W-1:0] rdEntry,
    output logic [FIFO_ADDR_W:0] wptrGray
);

    typedef struct packed {
        speed_t speedS1;
        speed_t speedS2;
        logic [FIFO_ADDR_W:0] rS1;
        logic [FIFO_ADDR_W:0] rS2;
        logic [FIFO_ADDR_W:0] wptr;
        logic [FIFO_ADDR_W:0] wgray;
        logic [3:0] riseData;
        logic riseCtl;
        logic [3:0] lowNib;
        logic lowErr;
        logic haveLow;
    } cap_t;

    cap_t r;
    cap_t next_r;
    logic [3:0] fallData;
    logic fallCtl;
    logic [TX_ENTRY_W-1:0] mem [0:(1<<FIFO_ADDR_W)-1];
    logic push;
    logic full;
    logic [TX_ENTRY_W-1:0] entry;

    // falling-edge half of the pin capture
    always_ff @(negedge txClk or negedge resetn) begin
        if (!resetn) begin
            fallData <= 4'h0;
            fallCtl <= 1'b0;
        end else begin
            fallData <= txData;
            fallCtl <= txCtl;
        end
    end

    // one full-cycle window: rise values from last edge, fall in between
    always_comb begin
        logic en;
        logic er;
        en = 1'b0;
        er = 1'b0;
        next_r = r;
        push = 1'b0;
        entry = '0;
        next_r.speedS1 = speed;
        next_r.speedS2 = r.speedS1;
        next_r.rS1 = rptrGray;
        next_r.rS2 = r.rS1;
        next_r.riseData = txData;
        next_r.riseCtl = txCtl;
        en = r.riseCtl;
        er = r.riseCtl ^ fallCtl;
        if (r.speedS2 == SPEED_1000) begin
            next_r.haveLow = 1'b0;
            if (en || er) begin
                push = 1'b1;
                entry = {en, er, fallData, r.riseData};
            end
        end else if (en || er) begin
            // slow speeds: one nibble per clock, low nibble first
            if (r.haveLow) begin
                push = 1'b1;
                entry = {en, er | r.lowErr, r.riseData, r.lowNib};
                next_r.haveLow = 1'b0;
            end else begin
                next_r.lowNib = r.riseData;
                next_r.lowErr = er;
                next_r.haveLow = 1'b1;
            end
        end else begin
            next_r.haveLow = 1'b0; // odd nibble at frame end is dropped
        end
        full = r.wgray == {~r.rS2[FIFO_ADDR_W:FIFO_ADDR_W-1],
                           r.rS2[FIFO_ADDR_W-2:0]};
        if (push && !full) begin
            next_r.wptr = r.wptr + 1'b1;
            next_r.wgray = bin2gray(r.wptr + 1'b1);
        end
    end

    always_ff @(posedge txClk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // storage carries no reset; an entry is written on the same edge its pointer moves
    always_ff @(posedge txClk) begin
        if (push && !full) begin
            mem[r.wptr[FIFO_ADDR_W-1:0]] <= entry;
        end
    end

    assign rdEntry = mem[rdAddr];
    assign wptrGray = r.wgray;

endmodule : rgmii_tx_capture

// ---- design/rgmii_port.sv ----
`timescale 1ns/1ps
module rgmii_port
    import rgmii_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic txClk,
    input wire logic [3:0] txData,
    input wire logic txCtl,
    output logic rxClk,
    output logic [3:0] rxData,
    output logic rxCtl,
    output logic rxPinsOe,
    input wire logic rxClkIn,
    input wire logic [3:0] rxDataIn,
    input wire logic rxCtlIn,
    output logic [STRAP_MODE_W-1:0] strapMode,
    output logic strapRefClkEnable,
    output logic refClockOut125,
    output logic refClockOe,
    input wire logic recoveredClk125,
    input wire logic syncEthSelect,
    input wire logic linkUp,
    input wire rgmii_port_pkg::speed_t speed,
    input wire logic fullDuplex,
    input wire logic [7:0] rxByte,
    input wire logic rxByteValid,
    input wire logic rxByteErr,
    output logic rxByteTaken,
    output logic [7:0] txByte,
    output logic txByteValid,
    output logic txByteErr,
    output logic txByteStrobe,
    output logic linePairThreePos,
    output logic linePairFourPos
);

    // the divider must reach every documented rate from the system clock
    if (SYS_CLK_HZ % RATE_10_HZ != 0 || SYS_CLK_HZ % RATE_100_HZ != 0 ||
        SYS_CLK_HZ != RATE_1000_HZ || SYS_CLK_HZ != REF_CLK_HZ ||
        FIFO_ADDR_W < 2) begin : g_check
        $error("rgmii_port: clock rates or queue depth unsupported");
    end

    typedef struct packed {
        port_state_t state;
        logic [1:0] strapCnt;
        logic [STRAP_VEC_W-1:0] strapS1;
        logic [STRAP_VEC_W-1:0] strapS2;
        logic [STRAP_MODE_W-1:0] strapMode;
        logic strapRefEn;
        logic pinsOe;
        speed_t curSpeed;
        logic [DIV_W-1:0] divCnt;
        logic highPhase;
        logic [7:0] rxHold;
        logic rxDv;
        logic rxEr;
        logic [3:0] riseNib;
        logic [3:0] fallNib;
        logic riseCtl;
        logic fallCtl;
        logic riseClk;
        logic fallClk;
        logic [FIFO_ADDR_W:0] wS1;
        logic [FIFO_ADDR_W:0] wS2;
        logic [FIFO_ADDR_W:0] rptr;
        logic [FIFO_ADDR_W:0] rgray;
        logic [7:0] txByte;
        logic txValid;
        logic txErr;
        logic txStrobe;
        logic pairsHigh;
    } port_state_s_t;

    port_state_s_t r;
    port_state_s_t next_r;
    logic [3:0] fallNibQ;
    logic fallCtlQ;
    logic fallClkQ;
    logic [TX_ENTRY_W-1:0] rdEntry;
    logic [FIFO_ADDR_W:0] wptrGray;
    logic running;
    logic rxTake;
    logic [3:0] statusNib;
    logic [7:0] byteSel;
    logic selDv;
    logic selEr;
    logic [DIV_W:0] riseHalf;
    logic [DIV_W:0] fallHalf;
    logic [DIV_W:0] halves;
    logic [DIV_W-1:0] period;
    logic localRef;

    // transmit pins are captured on the mac clock and queued across
    rgmii_tx_capture u_tx_capture (
        .txClk(txClk),
        .resetn(resetn),
        .txData(txData),
        .txCtl(txCtl),
        .speed(r.curSpeed),
        .rptrGray(r.rgray),
        .rdAddr(r.rptr[FIFO_ADDR_W-1:0]),
        .rdEntry(rdEntry),
        .wptrGray(wptrGray)
    );

    // in-band status and take handshake, visible in the same cycle
    always_comb begin
        running = r.state == ST_RUN;
        period = periodOf(r.curSpeed);
        statusNib = '0;
        statusNib[STAT_LINK_BIT] = linkUp;
        statusNib[STAT_SPEED_LSB +: 2] = speed;
        statusNib[STAT_DUPLEX_BIT] = fullDuplex;
        rxTake = running && r.divCnt == '0 && !r.highPhase;
        rxByteTaken = rxTake && (rxByteValid || rxByteErr);
        if (rxByteValid || rxByteErr) begin
            byteSel = rxByte;
        end else begin
            byteSel = {statusNib, statusNib};
        end
        selDv = rxTake ? rxByteValid : r.rxDv;
        selEr = rxTake ? rxByteErr : r.rxEr;
        riseHalf = {r.divCnt, 1'b0};
        fallHalf = {r.divCnt, 1'b1};
        halves = {1'b0, period};
    end

    // strap capture, receive serialiser and transmit queue drain
    always_comb begin
        next_r = r;
        next_r.strapS1 = {rxClkIn, rxCtlIn, rxDataIn};
        next_r.strapS2 = r.strapS1;
        case (r.state)
            ST_SETTLE: begin
                // rx pads stay released so the straps can be read
                if (r.strapCnt == STRAP_SETTLE) begin
                    next_r.strapMode = {r.strapS2[5], r.strapS2[3:0]};
                    next_r.strapRefEn = r.strapS2[4];
                    next_r.pinsOe = 1'b1;
                    next_r.curSpeed = speed;
                    next_r.state = ST_RUN;
                end else begin
                    next_r.strapCnt = r.strapCnt + 1'b1;
                end
            end
            ST_RUN: begin
                next_r.divCnt = (r.divCnt == period - 1'b1) ? '0
                                : r.divCnt + 1'b1;
                // clock high for the first half of each link period
                next_r.riseClk = riseHalf < halves;
                next_r.fallClk = fallHalf < halves;
                next_r.riseCtl = (riseHalf < halves) ? selDv
                                 : selDv ^ selEr;
                next_r.fallCtl = (fallHalf < halves) ? selDv
                                 : selDv ^ selEr;
                if (rxTake) begin
                    next_r.rxDv = rxByteValid;
                    next_r.rxEr = rxByteErr;
                    next_r.rxHold = byteSel;
                end
                if (r.divCnt == '0) begin
                    if (r.curSpeed == SPEED_1000) begin
                        next_r.riseNib = byteSel[3:0];
                        next_r.fallNib = byteSel[7:4];
                    end else if (!r.highPhase) begin
                        next_r.riseNib = byteSel[3:0];
                        next_r.fallNib = byteSel[3:0];
                        next_r.highPhase = 1'b1;
                    end else begin
                        next_r.riseNib = r.rxHold[7:4];
                        next_r.fallNib = r.rxHold[7:4];
                        next_r.highPhase = 1'b0;
                    end
                end
                // speed only changes on a byte boundary of the link clock
                if (next_r.divCnt == '0 && !next_r.highPhase) begin
                    next_r.curSpeed = speed;
                end
                next_r.pairsHigh = r.curSpeed == SPEED_1000;
            end
            default: begin
                next_r.state = ST_SETTLE;
            end
        endcase
        next_r.wS1 = wptrGray;
        next_r.wS2 = r.wS1;
        next_r.txStrobe = 1'b0;
        // queue drains at system rate, equal to the gigabit byte rate and faster than the slower ones
        if (r.rgray != r.wS2) begin
            next_r.txByte = rdEntry[7:0];
            next_r.txErr = rdEntry[ENTRY_ERR_BIT];
            next_r.txValid = rdEntry[ENTRY_VALID_BIT];
            next_r.txStrobe = 1'b1;
            next_r.rptr = r.rptr + 1'b1;
            next_r.rgray = bin2gray(r.rptr + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // falling-edge half of the output register pair
    always_ff @(negedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fallNibQ <= 4'h0;
            fallCtlQ <= 1'b0;
            fallClkQ <= 1'b0;
        end else begin
            fallNibQ <= r.fallNib;
            fallCtlQ <= r.fallCtl;
            fallClkQ <= r.fallClk;
        end
    end

    // double-rate pin mux: the clock level picks the half being shown
    assign rxData = clk_sys ? r.riseNib : fallNibQ;
    assign rxCtl = clk_sys ? r.riseCtl : fallCtlQ;
    assign rxClk = clk_sys ? r.riseClk : fallClkQ;
    assign rxPinsOe = r.pinsOe;

    // reference output: local clock, or recovered clock for sync use
    assign localRef = clk_sys & r.strapRefEn;
    assign refClockOut125 = syncEthSelect
                            ? (recoveredClk125 & r.strapRefEn)
                            : localRef;
    assign refClockOe = r.strapRefEn;

    assign strapMode = r.strapMode;
    assign strapRefClkEnable = r.strapRefEn;
    assign linePairThreePos = r.pairsHigh;
    assign linePairFourPos = r.pairsHigh;
    assign txByte = r.txByte;
    assign txByteValid = r.txValid;
    assign txByteErr = r.txErr;
    assign txByteStrobe = r.txStrobe;

endmodule : rgmii_port

// ---- test/rgmii_port_monitor.sv ----
`timescale 1ns/1ps
// watches the rx pad mux, straps, ref clock and tx hand-off of the port
module rgmii_port_monitor
    import rgmii_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic rxClk,
    input wire logic [3:0] rxData,
    input wire logic rxCtl,
    input wire logic rxPinsOe,
    input wire logic [STRAP_MODE_W-1:0] strapMode,
    input wire logic strapRefClkEnable,
    input wire logic refClockOut125,
    input wire logic refClockOe,
    input wire rgmii_port_pkg::speed_t speed,
    input wire logic linkUp,
    input wire logic fullDuplex,
    input wire logic [7:0] rxByte,
    input wire logic rxByteValid,
    input wire logic rxByteErr,
    input wire logic rxByteTaken,
    input wire logic [7:0] txByte,
    input wire logic txByteStrobe,
    input wire logic linePairThreePos,
    input wire logic linePairFourPos
);
    // falling-edge samples see the clock-high half of the pad mux
    a_gig_rise_nibble: assert property (@(negedge clk_sys)
        disable iff (!resetn) $past(rxByteTaken) && speed == SPEED_1000
        |-> rxData == $past(rxByte[3:0])) else $error("low nibble wrong");
    a_gig_clock_high: assert property (@(negedge clk_sys)
        disable iff (!resetn) rxPinsOe && $past(rxPinsOe) &&
        speed == SPEED_1000 |-> rxClk)
        else $error("rx clock not high in first half");
    // rising-edge samples see the clock-low half of the previous cycle
    a_gig_fall_half: assert property (@(posedge clk_sys)
        disable iff (!resetn) rxByteTaken && speed == SPEED_1000 |-> ##1
        (rxData == $past(rxByte[7:4]) &&
        rxCtl == ($past(rxByteValid) ^ $past(rxByteErr))))
        else $error("high nibble or control wrong");
    a_idle_status: assert property (@(posedge clk_sys)
        disable iff (!resetn) rxPinsOe && speed == SPEED_1000 &&
        !rxByteValid && !rxByteErr |-> ##1 (!rxCtl && rxData ==
        {$past(fullDuplex), $past(speed), $past(linkUp)}))
        else $error("status nibble wrong");
    a_slow_spacing: assert property (@(posedge clk_sys)
        disable iff (!resetn) rxByteTaken && speed == SPEED_100
        |=> !rxByteTaken [*8]) else $error("takes too close");
    a_pair_speed: assert property (@(posedge clk_sys)
        disable iff (!resetn) rxPinsOe && $past(rxPinsOe) |->
        linePairThreePos == (speed == SPEED_1000) &&
        linePairFourPos == linePairThreePos) else $error("pair use wrong");
    a_ref_enable: assert property (@(posedge clk_sys)
        disable iff (!resetn) refClockOe == strapRefClkEnable &&
        (strapRefClkEnable || !refClockOut125))
        else $error("ref clock not gated by strap");
    a_strap_hold: assert property (@(posedge clk_sys)
        disable iff (!resetn) rxPinsOe |=> $stable(strapMode))
        else $error("strap moved after latch");
    a_tx_strobe: assert property (@(posedge clk_sys)
        disable iff (!resetn) $changed(txByte) |-> txByteStrobe)
        else $error("tx byte moved without strobe");
endmodule : rgmii_port_monitor

bind rgmii_port rgmii_port_monitor u_rgmii_port_monitor (.clk_sys,
    .resetn, .rxClk, .rxData, .rxCtl, .rxPinsOe, .strapMode,
    .strapRefClkEnable, .refClockOut125, .refClockOe, .speed, .linkUp,
    .fullDuplex, .rxByte, .rxByteValid, .rxByteErr, .rxByteTaken,
    .txByte, .txByteStrobe, .linePairThreePos, .linePairFourPos);

// ---- test/mac_tx_model.sv ----
`timescale 1ns/1ps
// mac transmit side; its clock stands still between frames
module mac_tx_model (
    output logic txClk,
    output logic [3:0] txData,
    output logic txCtl
);
    initial begin
        txClk = 1'b0;
        txData = 4'h5;
        txCtl = 1'b0;
    end
    // one 80 ns link cycle, data moved mid-way between edges for setup
    task automatic cyc(input logic [3:0] r, input logic cr,
        input logic [3:0] f, input logic cf);
        txData = r;
        txCtl = cr;
        #20 txClk = 1'b1;
        #20 txData = f;
        txCtl = cf;
        #20 txClk = 1'b0;
        #20;
    endtask : cyc
    // idle lines carry a changing pattern so a stale nibble cannot match
    task automatic send(input logic [31:0] d, input logic [3:0] er,
        input bit gig);
        logic [7:0] b;
        repeat (4) cyc(~txData, 1'b0, txData, 1'b0);
        for (int i = 0; i < 4; i++) begin
            b = d[8*i+:8];
            if (gig) cyc(b[3:0], 1'b1, b[7:4], ~er[i]);
            else begin
                cyc(b[3:0], 1'b1, b[3:0], ~er[i]);
                cyc(b[7:4], 1'b1, b[7:4], ~er[i]);
            end
        end
        cyc(~txData, 1'b0, txData, 1'b0);
        txData = ~txData;
    endtask : send
endmodule : mac_tx_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
    import rgmii_port_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic recoveredClk125 = 1'b0;
    logic syncEthSelect = 1'b0;
    logic linkUp = 1'b0;
    logic fullDuplex = 1'b0;
    speed_t speed = SPEED_1000;
    logic [7:0] rxByte = 8'h00;
    logic rxByteValid = 1'b0;
    logic rxByteErr = 1'b0;
    logic [5:0] strap = 6'h00;
    logic txClk, txCtl, rxClk, rxCtl, rxPinsOe, rxByteTaken, txByteValid;
    logic strapRefClkEnable, refClockOut125, refClockOe, txByteErr;
    logic txByteStrobe, linePairThreePos, linePairFourPos;
    logic [3:0] txData, rxData;
    logic [7:0] txByte;
    logic [STRAP_MODE_W-1:0] strapMode;
    logic [9:0] got[$];
    int miscompares = 0;
    int checked = 0;
    // shared pads: straps from the board until the port drives them
    wire logic [5:0] pad = rxPinsOe ? {rxCtl, rxClk, rxData} : strap;

    always #4 clk_sys = ~clk_sys;
    initial begin
        #2;
        forever #4 recoveredClk125 = ~recoveredClk125;
    end
    // strobe is registered, so the falling edge sees it settled
    always @(negedge clk_sys) if (txByteStrobe === 1'b1)
        got.push_back({txByteErr, txByteValid, txByte});

    rgmii_port u_rgmii_port (.clk_sys, .resetn, .txClk, .txData, .txCtl,
        .rxClk, .rxData, .rxCtl, .rxPinsOe, .rxClkIn(pad[4]),
        .rxDataIn(pad[3:0]), .rxCtlIn(pad[5]), .strapMode,
        .strapRefClkEnable, .refClockOut125, .refClockOe, .recoveredClk125,
        .syncEthSelect, .linkUp, .speed, .fullDuplex, .rxByte, .rxByteValid,
        .rxByteErr, .rxByteTaken, .txByte, .txByteValid, .txByteErr,
        .txByteStrobe, .linePairThreePos, .linePairFourPos);
    mac_tx_model u_mac_tx_model (.txClk, .txData, .txCtl);

    task automatic chk(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // link clock period in system cycles for the current line speed
    function automatic int per();
        if (speed == SPEED_1000) return SYS_CLK_HZ / RATE_1000_HZ;
        if (speed == SPEED_100) return SYS_CLK_HZ / RATE_100_HZ;
        return SYS_CLK_HZ / RATE_10_HZ;
    endfunction : per
    task automatic do_reset(input speed_t s);
        @(posedge clk_sys);
        resetn <= 1'b0;
        speed <= s;
        strap <= 6'($urandom);
        syncEthSelect <= 1'($urandom);
        linkUp <= 1'($urandom);
        fullDuplex <= 1'($urandom);
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("strapMode", 8'(strapMode), 8'(strap[4:0]));
        chk("refOe", 8'(refClockOe), 8'(strap[5]));
        chk("pairThree", 8'(linePairThreePos), 8'(s == SPEED_1000));
        chk("pairFour", 8'(linePairFourPos), 8'(s == SPEED_1000));
        repeat (2) begin
            #4 chk("refClk", 8'(refClockOut125), 8'(strap[5] &
                (syncEthSelect ? recoveredClk125 : clk_sys)));
        end
    endtask : do_reset
    // idle slots show {duplex, speed, link} in both nibbles
    task automatic rx_byte(input logic [7:0] b, input logic v,
        input logic e);
        int n;
        logic [3:0] st;
        st = {fullDuplex, speed, linkUp};
        @(posedge clk_sys);
        rxByte <= b;
        rxByteValid <= v;
        rxByteErr <= e;
        n = 0;
        if (v | e) begin
            do begin
                @(negedge clk_sys);
                n++;
            end while (rxByteTaken !== 1'b1 && n < 200);
            chk("taken", 8'(rxByteTaken), 8'h01);
        end else begin
            repeat (2 * per()) @(negedge clk_sys);
            // slow idle slots: line up with a fresh rise of the link clock
            if (speed != SPEED_1000) begin
                do begin
                    @(posedge clk_sys);
                    #1 n++;
                end while (rxClk !== 1'b0 && n < 200);
                while (rxClk !== 1'b1 && n < 200) begin
                    @(posedge clk_sys);
                    #1 n++;
                end
            end
        end
        @(posedge clk_sys);
        rxByteValid <= 1'b0;
        rxByteErr <= 1'b0;
        #1 chk("rxLo", 8'(rxData), 8'((v | e) ? b[3:0] : st));
        chk("rxCtlRise", 8'(rxCtl), 8'(v));
        chk("rxClkRise", 8'(rxClk), 8'h01);
        if (speed == SPEED_1000) @(negedge clk_sys);
        else repeat (per()) @(posedge clk_sys);
        #1 chk("rxHi", 8'(rxData), 8'((v | e) ? b[7:4] : st));
        chk("rxCtlFall", 8'(rxCtl),
            8'(speed == SPEED_1000 ? v ^ e : v));
    endtask : rx_byte
    task automatic tx_frame(input bit gig);
        logic [31:0] d;
        logic [3:0] er;
        logic [9:0] g;
        d = $urandom;
        er = 4'($urandom);
        got.delete();
        u_mac_tx_model.send(d, er, gig);
        repeat (30) @(posedge clk_sys);
        chk("txCount", 8'(got.size()), 8'h04);
        for (int i = 0; i < 4 && got.size() > 0; i++) begin
            g = got.pop_front();
            chk("txByte", g[7:0], d[8*i+:8]);
            chk("txValid", 8'(g[8]), 8'h01);
            chk("txErr", 8'(g[9]), 8'(er[i]));
        end
    endtask : tx_frame

    initial begin
        speed_t sp[3] = '{SPEED_1000, SPEED_100, SPEED_10};
        void'($urandom(59));
        for (int k = 0; k < 3; k++) begin
            do_reset(sp[k]);
            rx_byte(8'ha5, 1'b1, 1'b0);
            rx_byte(8'h0f, 1'b0, 1'b1); // code with error only
            rx_byte(8'h3c, 1'b0, 1'b0); // idle slot
            rx_byte(8'hc3, 1'b1, 1'b1);
            for (int i = 0; i < 12; i++)
                rx_byte(8'($urandom), 1'($urandom), 1'($urandom));
            tx_frame(sp[k] == SPEED_1000);
            $display("test %0d at speed %0d done", k, sp[k]);
        end
        end_of_test();
    end
    // runs take well under 100 us; this bound only cuts a hang short
    initial begin
        #500_000;
        miscompares++;
        end_of_test();
    end
endmodule : tb
